// ==== design/half_bridge_fault_logic.v ====
`timescale 1ns/100ps
`default_nettype none
`include "hb_consts.vh"

module half_bridge_fault_logic #(
  parameter integer CNT_W = `HB_CNT_W,
  parameter integer OC_FILT_CYCLES =
    (`HB_OC_FILT_NS * `HB_CLK_MHZ + 999) / 1000,
  parameter integer ILIM_FILT_CYCLES =
    (`HB_ILIM_FILT_NS * `HB_CLK_MHZ + 999) / 1000,
  parameter integer UL_DELAY_CYCLES =
    (`HB_UL_DELAY_NS * `HB_CLK_MHZ + 999) / 1000
) (
  input wire clock,
  input wire arst_n,
  // Serial link pins
  input wire sclk,
  input wire chip_select_n,
  input wire si,
  output wire so,
  output wire so_oe,
  // Analog comparator results, asynchronous to the core clock
  input wire [5:0] overcurrent_cmp,
  input wire [5:0] current_limit_cmp,
  input wire [5:0] underload_cmp,
  input wire overvoltage_cmp,
  input wire [2:0] thermal_warn_cmp,
  input wire [2:0] thermal_shutdown_cmp,
  // Gate drive enables, bit order matches frame bits 1 to 6
  output reg [5:0] bridge_switch_state,
  // Status view of the flags
  output wire overload_flag,
  output wire underload_flag,
  output wire supply_fail_flag,
  output wire thermal_warning_flag,
  output wire thermal_shutdown_latched
);

  localparam integer NDRV = `HB_NUM_DRV;
  localparam integer NPAIR = `HB_NUM_PAIR;
  localparam integer NCMP = 3 * NDRV + 1 + 2 * NPAIR;
  localparam [CNT_W-1:0] OC_LIM = OC_FILT_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] ILIM_LIM = ILIM_FILT_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] UL_LIM = UL_DELAY_CYCLES[CNT_W-1:0];

  // ----------------------------------------------------------------
  // Qualification counter step
  // ----------------------------------------------------------------
  // Counts while the condition holds and saturates at the limit;
  // a dropped condition or a restart brings it back to zero.
  function [CNT_W-1:0] qual_next;
    input [CNT_W-1:0] cnt;
    input cond;
    input restart;
    input [CNT_W-1:0] lim;
    begin
      if (!cond || restart)
        qual_next = {CNT_W{1'b0}};
      else if (cnt != lim)
        qual_next = cnt + 1'b1;
      else
        qual_next = cnt;
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [NCMP-1:0] cmp_meta_r;
  reg [NCMP-1:0] cmp_sync_r;
  reg [15:0] ctrl_r;
  reg [5:0] latch_off_r;
  reg tsd_latch_r;
  reg ovl_r;
  reg ul_flag_r;
  reg sf_flag_r;
  reg warn_r;
  reg [15:0] status_bits;
  reg [5:0] oc_hit;
  reg [5:0] ilim_hit;
  reg [5:0] ul_hit;
  reg [5:0] drive_nxt;

  wire frame_valid;
  wire [15:0] frame_word;
  wire [15:0] status_word;
  wire [5:0] oc_s;
  wire [5:0] ilim_s;
  wire [5:0] ul_s;
  wire ov_s;
  wire [2:0] warn_s;
  wire [2:0] tsd_s;
  wire clear_cmd;
  wire [5:0] cmd_on;
  wire oc_shut_en;
  wire ov_lock_en;
  wire [5:0] oc_kill;
  wire tsd_now;
  wire ov_lockout;

  // ----------------------------------------------------------------
  // Comparator synchronisers
  // ----------------------------------------------------------------
  // Two flops on every analog flag before any logic sees it;
  // the comparators toggle freely, so one flop alone could
  // hand a metastable level to several timers at once.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmp_meta_r <= {NCMP{1'b0}};
      cmp_sync_r <= {NCMP{1'b0}};
    end else begin
      cmp_meta_r <= {thermal_shutdown_cmp, thermal_warn_cmp,
                     overvoltage_cmp, underload_cmp,
                     current_limit_cmp, overcurrent_cmp};
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // Unpack the synchronised flags
  assign oc_s = cmp_sync_r[5:0];
  assign ilim_s = cmp_sync_r[11:6];
  assign ul_s = cmp_sync_r[17:12];
  assign ov_s = cmp_sync_r[18];
  assign warn_s = cmp_sync_r[21:19];
  assign tsd_s = cmp_sync_r[24:22];

  // ----------------------------------------------------------------
  // Serial link front end
  // ----------------------------------------------------------------
  spi_frame_rx #(
    .FRAME_BITS(`HB_FRAME_BITS)
  ) u_link (
    .clock(clock),
    .arst_n(arst_n),
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .si(si),
    .status_word(status_word),
    .so(so),
    .so_oe(so_oe),
    .frame_valid(frame_valid),
    .frame_word(frame_word)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Frame fields, only meaningful while frame_valid is high
  assign clear_cmd = frame_valid & frame_word[`HB_BIT_CLEAR];
  assign cmd_on = frame_word[`HB_BIT_SW_MSB:`HB_BIT_SW_LSB];
  assign oc_shut_en = ctrl_r[`HB_BIT_OC_SHUT];
  assign ov_lock_en = ctrl_r[`HB_BIT_OV_LOCK];
  assign tsd_now = |tsd_s;
  assign ov_lockout = ov_lock_en & ov_s;

  // Overcurrent kills a driver only with shutdown enabled;
  // otherwise it is only reported and the driver keeps running.
  assign oc_kill = oc_hit & {6{oc_shut_en}};

  // Control word applied at the end of a valid frame
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `HB_CTRL_RST;
    end else if (frame_valid) begin
      ctrl_r <= frame_word;
    end
  end

  // ----------------------------------------------------------------
  // Per-driver qualification timers
  // ----------------------------------------------------------------
  // Every valid frame restarts the filters, so a fault that is
  // still present latches again one filter time later.
  // Under-load only counts while its driver is on, so an idle
  // output never reports an open load.
  genvar gi;
  generate
    for (gi = 0; gi < NDRV; gi = gi + 1) begin : g_drv
      reg [CNT_W-1:0] oc_cnt_r;
      reg [CNT_W-1:0] ilim_cnt_r;
      reg [CNT_W-1:0] ul_cnt_r;

      // Overcurrent, current limit and under-load timers
      always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          oc_cnt_r <= {CNT_W{1'b0}};
          ilim_cnt_r <= {CNT_W{1'b0}};
          ul_cnt_r <= {CNT_W{1'b0}};
        end else begin
          oc_cnt_r <= qual_next(oc_cnt_r, oc_s[gi],
                                frame_valid, OC_LIM);
          ilim_cnt_r <= qual_next(ilim_cnt_r, ilim_s[gi],
                                  frame_valid, ILIM_LIM);
          ul_cnt_r <= qual_next(ul_cnt_r,
                                ul_s[gi] & bridge_switch_state[gi],
                                frame_valid, UL_LIM);
        end
      end

      // Hit flags once a timer has run full
      always @* begin
        oc_hit[gi] = (oc_cnt_r == OC_LIM);
        ilim_hit[gi] = (ilim_cnt_r == ILIM_LIM);
        ul_hit[gi] = (ul_cnt_r == UL_LIM);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Driver latch-off
  // ----------------------------------------------------------------
  // A latched driver is released only by a clear command; a new
  // hit in the same cycle keeps it latched.
  // The latch sits apart from ctrl_r so the programmed state is
  // kept and comes back once the clear arrives.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latch_off_r <= 6'h00;
    end else begin
      latch_off_r <= (latch_off_r & ~{6{clear_cmd}})
                     | ilim_hit
                     | oc_kill;
    end
  end

  // ----------------------------------------------------------------
  // Thermal shutdown latch
  // ----------------------------------------------------------------
  // Released only when every pair has cooled past hysteresis and
  // a clear command also asks for at least one driver on.
  // A still-hot comparator wins, so a clear sent too early is
  // simply ignored and the drivers stay off.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tsd_latch_r <= 1'b0;
    end else if (tsd_now) begin
      tsd_latch_r <= 1'b1;
    end else if (clear_cmd && (|cmd_on)) begin
      tsd_latch_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sticky fault flags
  // ----------------------------------------------------------------
  // Set wins over clear for every flag.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ovl_r <= 1'b0;
      ul_flag_r <= 1'b0;
      sf_flag_r <= 1'b0;
      warn_r <= 1'b0;
    end else begin
      // Overload from either overcurrent or current limit
      if ((|oc_hit) || (|ilim_hit))
        ovl_r <= 1'b1;
      else if (clear_cmd)
        ovl_r <= 1'b0;
      // Under-load never touches the drivers
      if (|ul_hit)
        ul_flag_r <= 1'b1;
      else if (clear_cmd)
        ul_flag_r <= 1'b0;
      // Supply fail follows overvoltage in both lockout modes
      if (ov_s)
        sf_flag_r <= 1'b1;
      else if (clear_cmd)
        sf_flag_r <= 1'b0;
      // Thermal warning from any of the three pairs
      if (|warn_s)
        warn_r <= 1'b1;
      else if (clear_cmd)
        warn_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Driver enables
  // ----------------------------------------------------------------
  // Programmed states stay in ctrl_r, so an overvoltage lockout
  // only masks them and they return when the supply recovers.
  always @* begin
    drive_nxt = ctrl_r[`HB_BIT_SW_MSB:`HB_BIT_SW_LSB];
    drive_nxt = drive_nxt & ~latch_off_r;
    if (tsd_now || tsd_latch_r)
      drive_nxt = 6'h00;
    if (ov_lockout)
      drive_nxt = 6'h00;
  end

  // Registered gate drive
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bridge_switch_state <= 6'h00;
    end else begin
      bridge_switch_state <= drive_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status word and flag outputs
  // ----------------------------------------------------------------
  // Driver bits report the real drive, so a killed driver reads 0.
  // Fields are placed by position so the frame layout lives in
  // the constants header only; unused bits stay zero.
  always @* begin
    status_bits = 16'h0000;
    status_bits[`HB_BIT_WARN] = warn_r;
    status_bits[`HB_BIT_SW_MSB:`HB_BIT_SW_LSB] = bridge_switch_state;
    status_bits[`HB_BIT_OVERLOAD] = ovl_r;
    status_bits[`HB_BIT_UNDERLOAD] = ul_flag_r;
    status_bits[`HB_BIT_SUPPLY_FAIL] = sf_flag_r;
  end
  assign status_word = status_bits;
  assign overload_flag = ovl_r;
  assign underload_flag = ul_flag_r;
  assign supply_fail_flag = sf_flag_r;
  assign thermal_warning_flag = warn_r;
  assign thermal_shutdown_latched = tsd_latch_r;

endmodule
`default_nettype wire

// ==== common/hb_consts.vh ====
`ifndef HB_CONSTS_VH
`define HB_CONSTS_VH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define HB_FRAME_BITS 16
`define HB_BITCNT_W 5
`define HB_BIT_CLEAR 0
`define HB_BIT_SW_LSB 1
`define HB_BIT_SW_MSB 6
`define HB_BIT_OC_SHUT 13
`define HB_BIT_OV_LOCK 15
`define HB_BIT_WARN 0
`define HB_BIT_OVERLOAD 13
`define HB_BIT_UNDERLOAD 14
`define HB_BIT_SUPPLY_FAIL 15
`define HB_NUM_DRV 6
`define HB_NUM_PAIR 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HB_CTRL_RST 16'h0000
`define HB_STAT_RST 16'h0000

// ----------------------------------------------------------------
// Timing, core clock rate and filter times in ns
// ----------------------------------------------------------------
`define HB_CLK_MHZ 200
`define HB_OC_FILT_NS 25000
`define HB_ILIM_FILT_NS 200000
`define HB_UL_DELAY_NS 200000
`define HB_CNT_W 16

`endif

// ==== design/spi_frame_rx.v ====
`timescale 1ns/100ps
`default_nettype none
`include "hb_consts.vh"

module spi_frame_rx #(
  parameter integer FRAME_BITS = `HB_FRAME_BITS
) (
  input wire clock,
  input wire arst_n,
  input wire sclk,
  input wire chip_select_n,
  input wire si,
  input wire [15:0] status_word,
  output reg so,
  output reg so_oe,
  output reg frame_valid,
  output reg [15:0] frame_word
);

  // Pin bundle order: {chip_select_n, sclk, si}
  reg [2:0] pin_meta_r;
  reg [2:0] pin_sync_r;
  reg [2:0] pin_last_r;
  reg [15:0] in_sr_r;
  reg [15:0] out_sr_r;
  reg [`HB_BITCNT_W-1:0] bit_cnt_r;

  wire cs_low = ~pin_sync_r[2];
  wire cs_fall = pin_last_r[2] & ~pin_sync_r[2];
  wire cs_rise = ~pin_last_r[2] & pin_sync_r[2];
  wire sclk_rise = cs_low & ~pin_last_r[1] & pin_sync_r[1];
  wire sclk_fall = cs_low & pin_last_r[1] & ~pin_sync_r[1];
  wire frame_long = (bit_cnt_r >= FRAME_BITS[`HB_BITCNT_W-1:0]);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_r <= 3'h4;
      pin_sync_r <= 3'h4;
      pin_last_r <= 3'h4;
    end else begin
      pin_meta_r <= {chip_select_n, sclk, si};
      pin_sync_r <= pin_meta_r;
      pin_last_r <= pin_sync_r;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine, frame length check, serial out
  // ----------------------------------------------------------------
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_sr_r <= 16'h0000;
      out_sr_r <= 16'h0000;
      bit_cnt_r <= {`HB_BITCNT_W{1'b0}};
      so <= 1'b0;
      so_oe <= 1'b0;
      frame_valid <= 1'b0;
      frame_word <= 16'h0000;
    end else begin
      if (cs_fall) begin
        out_sr_r <= status_word;
        bit_cnt_r <= {`HB_BITCNT_W{1'b0}};
      end else begin
        // Shift only while selected
        // A rise empties the top slot and the next fall fills it with
        // the sampled input, so a chained device sees it 16 bits later.
        if (sclk_rise) begin
          out_sr_r <= {1'b0, out_sr_r[15:1]};
          if (!frame_long)
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
        if (sclk_fall) begin
          in_sr_r <= {pin_sync_r[0], in_sr_r[15:1]};
          out_sr_r[15] <= pin_sync_r[0];
        end
      end
      so <= out_sr_r[0];
      so_oe <= cs_low;
      // Accept only long enough frames that end with the clock low
      frame_valid <= cs_rise & frame_long & ~pin_sync_r[1];
      if (cs_rise & frame_long & ~pin_sync_r[1])
        frame_word <= in_sr_r;
    end
  end

endmodule
`default_nettype wire

// ==== test/half_bridge_fault_logic_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module half_bridge_fault_logic_sva #(
  parameter integer ILIM_FILT_CYCLES = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [5:0] overcurrent_cmp,
  input wire logic [5:0] current_limit_cmp,
  input wire logic [5:0] underload_cmp,
  input wire logic overvoltage_cmp,
  input wire logic [2:0] thermal_warn_cmp,
  input wire logic [2:0] thermal_shutdown_cmp,
  input wire logic [5:0] bridge_switch_state,
  input wire logic overload_flag,
  input wire logic underload_flag,
  input wire logic supply_fail_flag,
  input wire logic thermal_warning_flag,
  input wire logic thermal_shutdown_latched
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Helper: cycles a steady current limit has lasted
  // ----------------------------------------
  logic [15:0] lim_cnt_r;
  logic [5:0] lim_prev_r;
  // Restarts on any change so a new short is timed afresh
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lim_cnt_r <= 16'h0000;
      lim_prev_r <= 6'h00;
    end else begin
      lim_prev_r <= current_limit_cmp;
      if (current_limit_cmp == 6'h00 || current_limit_cmp != lim_prev_r) begin
        lim_cnt_r <= 16'h0000;
      end else if (lim_cnt_r != 16'hffff) begin
        lim_cnt_r <= lim_cnt_r + 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_so_release;
    chip_select_n [*4] |-> !so_oe;
  endproperty
  a_so_release: assert property (p_so_release) else $error("so driven while deselected");
  property p_tw_sel;
    $fell(chip_select_n) |-> ##5 (so_oe && so == thermal_warning_flag);
  endproperty
  a_tw_sel: assert property (p_tw_sel) else $error("warning not shown on select");
  property p_ilim_off;
    lim_cnt_r == ILIM_FILT_CYCLES + 6 |->
      (bridge_switch_state & current_limit_cmp) == 6'h00 && overload_flag;
  endproperty
  a_ilim_off: assert property (p_ilim_off) else $error("shorted driver still on");
  property p_tsd_off;
    thermal_shutdown_latched ##1 thermal_shutdown_latched |-> bridge_switch_state == 6'h00;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("driver on in shutdown");
  property p_tsd_latch;
    $rose(|thermal_shutdown_cmp) |-> ##[1:5] thermal_shutdown_latched;
  endproperty
  a_tsd_latch: assert property (p_tsd_latch) else $error("shutdown not latched");
  property p_ov_flag;
    overvoltage_cmp [*3] |-> ##[0:4] supply_fail_flag;
  endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("supply fail not set");
  property p_tw_latch;
    $rose(|thermal_warn_cmp) |-> ##[1:5] thermal_warning_flag;
  endproperty
  a_tw_latch: assert property (p_tw_latch) else $error("warning not latched");
  property p_flag_hold;
    $fell(overload_flag) || $fell(underload_flag) |-> chip_select_n && $past(chip_select_n, 3);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag fell without frame");
  c_sel: cover property ($fell(chip_select_n));
  c_ilim: cover property (lim_cnt_r == ILIM_FILT_CYCLES + 6);
  c_ov: cover property ($rose(supply_fail_flag));
endmodule
`default_nettype wire

// ==== test/spi_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic sclk,
  output logic chip_select_n,
  output logic si,
  input wire logic so_line
);
  // Idle: deselected, clock parked low, data pulled down
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    si = 1'b0;
  end
  // Frame of n bits, LSB first, 64 ns link clock
  task automatic xfer(input logic [31:0] w, input int n, input logic sel,
                      output logic [31:0] rd);
    rd = 32'h00000000;
    chip_select_n = !sel;
    for (int i = 0; i < n; i++) begin
      #24 si = w[i];
      #8 rd[i] = so_line;
      sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 chip_select_n = 1'b1;
    si = 1'b0;
    #64;
  endtask
  // Select with a parked clock to read the warning level
  task automatic peek(input logic lvl, output logic v);
    sclk = lvl;
    #20 chip_select_n = 1'b0;
    #100 v = so_line;
    chip_select_n = 1'b1;
    #20 sclk = 1'b0;
    #64;
  endtask
endmodule
`default_nettype wire

// ==== test/test_half_bridge_fault_logic.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_half_bridge_fault_logic;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] overcurrent_cmp = 6'h00;
  logic [5:0] current_limit_cmp = 6'h00;
  logic [5:0] underload_cmp = 6'h00;
  logic overvoltage_cmp = 1'b0;
  logic [2:0] thermal_warn_cmp = 3'h0;
  logic [2:0] thermal_shutdown_cmp = 3'h0;
  wire sclk;
  wire chip_select_n;
  wire si;
  wire so;
  wire so_oe;
  wire [5:0] bridge_switch_state;
  wire overload_flag;
  wire underload_flag;
  wire supply_fail_flag;
  wire thermal_warning_flag;
  wire thermal_shutdown_latched;
  wire so_line = so_oe ? so : 1'bz;
  logic [31:0] rd;
  logic v;
  int err_total = 0;
  int comparisons = 0;
  logic [15:0] row_w [4] = '{16'h007e, 16'h002a, 16'h0054, 16'h0002};
  logic [5:0] row_sw [4] = '{6'h3f, 6'h15, 6'h2a, 6'h01};
  // 200 MHz core clock
  always #2.5 clock = ~clock;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  // Short filter times keep the run brief
  half_bridge_fault_logic #(
    .OC_FILT_CYCLES(8),
    .ILIM_FILT_CYCLES(8),
    .UL_DELAY_CYCLES(8)
  ) half_bridge_fault_logic_i (
    .clock(clock), .arst_n(arst_n), .sclk(sclk), .chip_select_n(chip_select_n),
    .si(si), .so(so), .so_oe(so_oe), .overcurrent_cmp(overcurrent_cmp),
    .current_limit_cmp(current_limit_cmp), .underload_cmp(underload_cmp),
    .overvoltage_cmp(overvoltage_cmp), .thermal_warn_cmp(thermal_warn_cmp),
    .thermal_shutdown_cmp(thermal_shutdown_cmp),
    .bridge_switch_state(bridge_switch_state), .overload_flag(overload_flag),
    .underload_flag(underload_flag), .supply_fail_flag(supply_fail_flag),
    .thermal_warning_flag(thermal_warning_flag),
    .thermal_shutdown_latched(thermal_shutdown_latched)
  );
  spi_host_model spi_host_model_i (
    .sclk(sclk), .chip_select_n(chip_select_n), .si(si), .so_line(so_line)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // Outputs packed: oe, shutdown, supply, under, over, warn, 0000, drivers
  function automatic logic [15:0] snap();
    return {so_oe, thermal_shutdown_latched, supply_fail_flag, underload_flag,
            overload_flag, thermal_warning_flag, 4'h0, bridge_switch_state};
  endfunction
  task automatic wr(input logic [15:0] w);
    spi_host_model_i.xfer({16'h0000, w}, 16, 1'b1, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(20);
    chk("reset", 16'h0000, snap());
    chk("so reset", 16'h0000, {15'h0000, so_line === 1'bz ? 1'b0 : 1'b1});
    arst_n = 1'b1;
    cyc(5);
    for (int i = 0; i < 4; i++) begin
      wr(row_w[i]);
      chk("drivers", {10'h000, row_sw[i]}, {10'h000, bridge_switch_state});
      wr(row_w[i]);
      chk("status", {9'h000, row_sw[i], 1'b0}, rd[15:0]);
    end
    overcurrent_cmp = 6'h01;
    cyc(30);
    chk("ocd off", 16'h0801, snap());
    overcurrent_cmp = 6'h00;
    wr(16'h2003);
    overcurrent_cmp = 6'h01;
    cyc(30);
    chk("ocd on", 16'h0800, snap());
    overcurrent_cmp = 6'h00;
    wr(16'h2002);
    chk("no clear", 16'h0800, snap());
    wr(16'h2003);
    chk("reenable", 16'h0001, snap());
    wr(16'h0005);
    current_limit_cmp = 6'h02;
    cyc(30);
    chk("ilim", 16'h0800, snap());
    current_limit_cmp = 6'h00;
    wr(16'h0004);
    chk("ilim status", 16'h2000, rd[15:0]);
    chk("ilim hold", 16'h0800, snap());
    wr(16'h0005);
    underload_cmp = 6'h02;
    cyc(30);
    chk("underload", 16'h1002, snap());
    underload_cmp = 6'h00;
    wr(16'h0004);
    chk("ul status", 16'h4004, rd[15:0]);
    wr(16'h0005);
    overvoltage_cmp = 1'b1;
    cyc(10);
    chk("ov flag", 16'h2002, snap());
    wr(16'h8005);
    cyc(10);
    chk("ov lock", 16'h2000, snap());
    overvoltage_cmp = 1'b0;
    cyc(10);
    chk("ov back", 16'h2002, snap());
    wr(16'h0005);
    chk("ov clear", 16'h0002, snap());
    thermal_warn_cmp = 3'h4;
    cyc(10);
    thermal_warn_cmp = 3'h0;
    cyc(5);
    chk("warn", 16'h0402, snap());
    spi_host_model_i.peek(1'b0, v);
    chk("warn so", 16'h0001, {15'h0000, v});
    spi_host_model_i.peek(1'b1, v);
    chk("warn sclk hi", 16'h0001, {15'h0000, v});
    chk("so idle", 16'h0000, {15'h0000, so_line === 1'bz ? 1'b0 : 1'b1});
    wr(16'h0005);
    spi_host_model_i.peek(1'b0, v);
    chk("warn clear", 16'h0000, {15'h0000, v});
    thermal_shutdown_cmp = 3'h2;
    cyc(10);
    chk("tsd", 16'h4000, snap());
    wr(16'h0005);
    chk("tsd hot", 16'h4000, snap());
    thermal_shutdown_cmp = 3'h0;
    wr(16'h0004);
    chk("tsd no clr", 16'h4000, snap());
    wr(16'h0005);
    chk("tsd release", 16'h0002, snap());
    spi_host_model_i.xfer(32'h0000007f, 8, 1'b1, rd);
    chk("short", 16'h0002, snap());
    spi_host_model_i.xfer(32'h0000007f, 16, 1'b0, rd);
    chk("deselected", 16'h0002, snap());
    spi_host_model_i.xfer(32'h000009a5, 24, 1'b1, rd);
    chk("daisy so", 16'h00a5, {8'h00, rd[23:16]});
    chk("daisy st", 16'h0004, rd[15:0]);
    chk("daisy in", 16'h0004, snap());
    give_verdict();
  end
endmodule
bind half_bridge_fault_logic half_bridge_fault_logic_sva #(
  .ILIM_FILT_CYCLES(ILIM_FILT_CYCLES)
) chk_i (.*);
`default_nettype wire
